// File: design/mrlc_top.sv
// monitor reset and loop control: reset sources, reset line, control register,
// round-robin monitoring sequencer and the result/limit storage.
// assumes the serial bus engine sits outside and presents a register port on
// its own clock; the converter answers each request with a one-cycle done pulse.
`timescale 1ns/100ps
module mrlc_top
   import mrlc_pkg::*;
#(
   parameter int PULSE_CYCLES = RST_PULSE_CYCLES,
   parameter int PERIOD_CYCLES = LOOP_PERIOD_CYCLES,
   parameter int CHANNELS = NUM_CHANNELS
) (
   // core clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // host register port, link domain
   input wire logic i_link_clk,
   input wire logic i_link_rst_n,
   input wire logic i_link_wr,
   input wire logic i_link_rd,
   input wire logic [7:0] i_link_addr,
   input wire logic [7:0] i_link_wdata,
   output logic o_link_busy,
   output logic o_link_rvalid,
   output logic [7:0] o_link_rdata,
   // bidirectional active-low reset line
   input wire logic i_rst_line,
   output logic o_rst_line,
   output logic o_rst_line_oe_n,
   // chassis intrusion line, open drain
   output logic o_case_open_line,
   output logic o_case_open_line_oe_n,
   // interrupt output and its source
   input wire logic i_int_pending,
   output logic o_int_n,
   // converter request and result
   output logic o_conv_req,
   output logic [3:0] o_conv_chan,
   input wire logic i_conv_done,
   input wire logic [7:0] i_conv_data,
   // loop status
   output logic o_loop_active
);
   // ---------------- link domain ----------------
   logic req_tgl_reg;
   logic req_is_rd_reg;
   logic [7:0] req_addr_reg;
   logic [7:0] req_data_reg;
   logic [2:0] ack_sync_reg;
   logic pend_reg;
   logic rvalid_reg;
   logic [7:0] rdata_link_reg;
   logic link_ack_seen;
   logic link_take;
   logic [2:0] req_sync_reg;
   logic ack_tgl_reg;
   logic [7:0] core_rdata_reg;

   // a change counts once the second and third stages agree
   assign link_ack_seen = pend_reg && (ack_sync_reg[1] == ack_sync_reg[2])
      && (ack_sync_reg[2] == req_tgl_reg);
   // requests during a pending transfer are ignored; busy tells the host
   assign link_take = !pend_reg && (i_link_wr || i_link_rd);

   always_ff @(posedge i_link_clk) begin
      if (!i_link_rst_n) begin
         req_tgl_reg <= 1'b0;
         req_is_rd_reg <= 1'b0;
         req_addr_reg <= 8'h00;
         req_data_reg <= 8'h00;
         ack_sync_reg <= 3'h0;
         pend_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_link_reg <= 8'h00;
      end else begin
         ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
         rvalid_reg <= link_ack_seen && req_is_rd_reg;
         if (link_take) begin
            req_tgl_reg <= !req_tgl_reg;
            req_is_rd_reg <= i_link_rd;
            req_addr_reg <= i_link_addr;
            req_data_reg <= i_link_wdata;
            pend_reg <= 1'b1;
         end else if (link_ack_seen) begin
            pend_reg <= 1'b0;
         end
         // core holds its read word steady until the next request
         if (link_ack_seen && req_is_rd_reg) begin
            rdata_link_reg <= core_rdata_reg;
         end
      end
   end

   assign o_link_busy = pend_reg;
   assign o_link_rvalid = rvalid_reg;
   assign o_link_rdata = rdata_link_reg;

   // ---------------- core domain: request crossing ----------------
   logic host_req;
   logic host_wr;

   assign host_req = (req_sync_reg[1] == req_sync_reg[2]) && (req_sync_reg[2] != ack_tgl_reg);
   assign host_wr = host_req && !req_is_rd_reg;

   // ---------------- reset line ----------------
   logic [2:0] rst_sync_reg;
   logic rst_low_reg;
   logic [31:0] pulse_cnt_reg;
   logic [31:0] pulse_cnt_next;
   logic [1:0] guard_reg;
   logic driving;
   logic ext_reset;
   logic sw_reset;
   logic init_req;
   logic defaults;
   logic [7:0] ctl_reg;
   logic [7:0] ctl_next;
   logic [7:0] mask2_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rst_sync_reg <= 3'h7;
         rst_low_reg <= 1'b0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[1:0], i_rst_line};
         if (rst_sync_reg[1] == rst_sync_reg[2]) begin
            rst_low_reg <= !rst_sync_reg[2];
         end
      end
   end

   assign driving = (pulse_cnt_reg != 32'h0);
   // own drive echoes back through the synchroniser; a high third stage means it has cleared
   assign ext_reset = rst_low_reg && !rst_sync_reg[2] && !driving && (guard_reg == 2'h0);
   assign sw_reset = ctl_reg[CTL_SW_RESET_BIT] && mask2_reg[MASK2_RESET_MODE_BIT];
   assign init_req = host_wr && (req_addr_reg == ADDR_DEVICE_CONTROL)
      && req_data_reg[CTL_INIT_BIT];
   // init and external reset restore defaults; the value area is kept
   assign defaults = ext_reset || init_req;

   always_comb begin
      pulse_cnt_next = pulse_cnt_reg;
      if (ext_reset || sw_reset) begin
         pulse_cnt_next = PULSE_CYCLES;
      end else if (driving) begin
         pulse_cnt_next = pulse_cnt_reg - 32'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pulse_cnt_reg <= PULSE_CYCLES;
         guard_reg <= 2'h0;
      end else begin
         pulse_cnt_reg <= pulse_cnt_next;
         if (driving) begin
            guard_reg <= RST_GUARD_CYCLES;
         end else if (guard_reg != 2'h0) begin
            guard_reg <= guard_reg - 2'h1;
         end
      end
   end

   // init_req never loads the counter, so the line stays released
   assign o_rst_line = 1'b0;
   assign o_rst_line_oe_n = !driving;

   // ---------------- control registers ----------------
   logic ctl_hit;
   logic mask2_hit;
   logic ram_hit;
   logic ram_wr_ok;

   assign ctl_hit = (req_addr_reg == ADDR_DEVICE_CONTROL);
   assign mask2_hit = (req_addr_reg == ADDR_INT_MASK2);
   assign ram_hit = (req_addr_reg >= ADDR_VALUE_FIRST) && (req_addr_reg <= ADDR_VALUE_LAST);
   // results are read-only; only the limit part takes host writes
   assign ram_wr_ok = ram_hit && (req_addr_reg > ADDR_RESULT_LAST);

   always_comb begin
      ctl_next = ctl_reg;
      if (host_wr && ctl_hit) begin
         ctl_next = req_data_reg;
      end
      // a pending software reset clears once the line goes active
      if (sw_reset) begin
         ctl_next[CTL_SW_RESET_BIT] = 1'b0;
      end
      if (defaults) begin
         ctl_next = DEVICE_CONTROL_RESET;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctl_reg <= DEVICE_CONTROL_RESET;
         mask2_reg <= INT_MASK2_RESET;
      end else begin
         ctl_reg <= ctl_next;
         if (defaults) begin
            mask2_reg <= INT_MASK2_RESET;
         end else if (host_wr && mask2_hit) begin
            mask2_reg <= req_data_reg;
         end
      end
   end

   // output released while clear is high or output disabled
   assign o_int_n = !(i_int_pending && ctl_reg[CTL_INT_ENABLE_BIT]
      && !ctl_reg[CTL_INT_CLEAR_BIT]);
   // pulling the line low resets the external intrusion latch
   assign o_case_open_line = 1'b0;
   assign o_case_open_line_oe_n = !ctl_reg[CTL_CASE_CLEAR_BIT];

   // ---------------- value area ----------------
   // no reset: contents undefined after power-up, kept over init and pin reset
   logic [7:0] value_mem [0:29];
   logic [4:0] host_idx;
   logic [4:0] conv_idx;
   logic [7:0] conv_addr;
   logic [7:0] rd_word;
   mrlc_loop_type loop_state_reg;
   logic [3:0] chan_reg;

   assign host_idx = 5'(req_addr_reg - ADDR_VALUE_FIRST);
   // channel 0 is temperature at its own location, the others follow in order
   assign conv_addr = (chan_reg == 4'h0) ? ADDR_TEMPERATURE_RESULT
      : (chan_reg < 4'h8) ? 8'(ADDR_VALUE_FIRST + 8'(chan_reg) - 8'h01)
      : 8'(ADDR_VALUE_FIRST + 8'(chan_reg));
   assign conv_idx = 5'(conv_addr - ADDR_VALUE_FIRST);

   always_ff @(posedge i_clk) begin
      // codes stored as converted: temperature already signed degrees,
      // supplies with nominal at VOLT_CODE_NOMINAL
      if (loop_state_reg == MRLC_LOOP_REQ && i_conv_done) begin
         value_mem[conv_idx] <= i_conv_data;
      end
      if (host_wr && ram_wr_ok) begin
         value_mem[host_idx] <= req_data_reg;
      end
   end

   assign rd_word = ctl_hit ? ctl_reg
      : mask2_hit ? mask2_reg
      : ram_hit ? value_mem[host_idx]
      : 8'h00;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         req_sync_reg <= 3'h0;
         ack_tgl_reg <= 1'b0;
         core_rdata_reg <= 8'h00;
      end else begin
         req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
         if (host_req) begin
            ack_tgl_reg <= req_sync_reg[2];
            core_rdata_reg <= rd_word;
         end
      end
   end

   // ---------------- monitoring loop ----------------
   logic [31:0] period_cnt_reg;
   logic run;
   logic last_chan;
   logic period_done;

   assign run = ctl_reg[CTL_START_BIT] && !ctl_reg[CTL_INT_CLEAR_BIT];
   assign last_chan = (chan_reg == 4'(CHANNELS - 1));
   assign period_done = (period_cnt_reg == 32'h0);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || defaults) begin
         loop_state_reg <= MRLC_LOOP_IDLE;
         chan_reg <= 4'h0;
         period_cnt_reg <= 32'h0;
      end else begin
         if (!period_done) begin
            period_cnt_reg <= period_cnt_reg - 32'h1;
         end
         case (loop_state_reg)
            MRLC_LOOP_IDLE: begin
               if (run) begin
                  chan_reg <= 4'h0;
                  period_cnt_reg <= PERIOD_CYCLES - 1;
                  loop_state_reg <= MRLC_LOOP_REQ;
               end
            end
            MRLC_LOOP_REQ: begin
               // a stop only takes effect at the end of the pass
               if (i_conv_done) begin
                  if (!last_chan) begin
                     chan_reg <= chan_reg + 4'h1;
                  end else if (run) begin
                     loop_state_reg <= MRLC_LOOP_GAP;
                  end else begin
                     loop_state_reg <= MRLC_LOOP_IDLE;
                  end
               end
            end
            MRLC_LOOP_GAP: begin
               if (!run) begin
                  loop_state_reg <= MRLC_LOOP_IDLE;
               end else if (period_done) begin
                  chan_reg <= 4'h0;
                  period_cnt_reg <= PERIOD_CYCLES - 1;
                  loop_state_reg <= MRLC_LOOP_REQ;
               end
            end
            default: begin
               loop_state_reg <= MRLC_LOOP_IDLE;
            end
         endcase
      end
   end

   assign o_conv_req = (loop_state_reg == MRLC_LOOP_REQ);
   assign o_conv_chan = chan_reg;
   assign o_loop_active = (loop_state_reg != MRLC_LOOP_IDLE);
endmodule

// File: shared/mrlc_pkg.sv
// constants shared by the monitor reset and loop control block
// assumes a 250 MHz core clock and a host-side register port on its own clock
package mrlc_pkg;
   // core clock rate and reset pulse timing
   localparam int CLK_FREQ_HZ = 250000000;
   localparam int RST_MIN_MS = 20;
   localparam int RST_PULSE_CYCLES = RST_MIN_MS * (CLK_FREQ_HZ / 1000);
   // time between starts of two monitoring passes
   localparam int LOOP_PERIOD_MS = 1000;
   localparam int LOOP_PERIOD_CYCLES = LOOP_PERIOD_MS * (CLK_FREQ_HZ / 1000);
   // cycles the line is ignored after release, covering the input synchroniser
   localparam logic [1:0] RST_GUARD_CYCLES = 2'h3;

   // register offsets
   localparam logic [7:0] ADDR_DEVICE_CONTROL = 8'h40;
   localparam logic [7:0] ADDR_INT_MASK2 = 8'h44;
   localparam logic [7:0] ADDR_TEMPERATURE_RESULT = 8'h27;
   localparam logic [7:0] ADDR_VALUE_FIRST = 8'h20;
   localparam logic [7:0] ADDR_VALUE_LAST = 8'h3d;
   // results occupy the low part of the value area, limits the rest
   localparam logic [7:0] ADDR_RESULT_LAST = 8'h29;

   // reset values
   localparam logic [7:0] DEVICE_CONTROL_RESET = 8'h08;
   localparam logic [7:0] INT_MASK2_RESET = 8'h00;

   // device_control field positions
   localparam int CTL_START_BIT = 0;
   localparam int CTL_INT_ENABLE_BIT = 1;
   localparam int CTL_INT_CLEAR_BIT = 3;
   localparam int CTL_SW_RESET_BIT = 4;
   localparam int CTL_CASE_CLEAR_BIT = 6;
   localparam int CTL_INIT_BIT = 7;
   // int_mask2 bit that places the reset line in reset mode
   localparam int MASK2_RESET_MODE_BIT = 7;

   // result encodings
   localparam logic [7:0] TEMP_CODE_PLUS_125 = 8'h7d;
   localparam logic [7:0] TEMP_CODE_ZERO = 8'h00;
   localparam logic [7:0] TEMP_CODE_MINUS_40 = 8'hd8;
   localparam logic [7:0] VOLT_CODE_NOMINAL = 8'hc0;

   // monitoring loop
   localparam int NUM_CHANNELS = 10;
   typedef enum logic [1:0] {
      MRLC_LOOP_IDLE,
      MRLC_LOOP_REQ,
      MRLC_LOOP_GAP
   } mrlc_loop_type;
endpackage

// File: verif/mrlc_host_model.sv
// host model: single-byte register requests on the link clock
// assumes the device answers within twenty link cycles
`timescale 1ns/100ps
module mrlc_host_model (
   // link clock
   input wire logic i_link_clk,
   // request side
   output logic o_link_wr,
   output logic o_link_rd,
   output logic [7:0] o_link_addr,
   output logic [7:0] o_link_wdata,
   // answer side
   input wire logic i_link_busy,
   input wire logic i_link_rvalid,
   input wire logic [7:0] i_link_rdata
);
   initial begin
      o_link_wr = 1'b0;
      o_link_rd = 1'b0;
      o_link_addr = 8'h00;
      o_link_wdata = 8'h00;
   end
   // one outstanding request; late flags a missing answer
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] r, output logic late);
      late = 1'b1;
      r = 8'h00;
      @(negedge i_link_clk);
      o_link_wr = w;
      o_link_rd = !w;
      o_link_addr = a;
      o_link_wdata = d;
      @(negedge i_link_clk);
      o_link_wr = 1'b0;
      o_link_rd = 1'b0;
      // released lines show no stale value
      o_link_addr = ~a;
      o_link_wdata = ~d;
      for (int n = 0; n < 20; n++) begin
         @(negedge i_link_clk);
         if (!i_link_busy) begin
            r = i_link_rdata;
            late = !w && !i_link_rvalid;
            break;
         end
      end
   endtask
endmodule

// File: verif/mrlc_props.sv
// checker for reset line timing, loop sequencing and register port handshake
// assumes it is bound to mrlc_top and sees only its ports
`timescale 1ns/100ps
module mrlc_props
   import mrlc_pkg::*;
#(
   parameter int PULSE_CYCLES = RST_PULSE_CYCLES,
   parameter int CHANNELS = NUM_CHANNELS
) (
   // clocks and resets
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_link_clk,
   input wire logic i_link_rst_n,
   // register port
   input wire logic i_link_wr,
   input wire logic i_link_rd,
   input wire logic o_link_busy,
   // pins
   input wire logic i_rst_line,
   input wire logic o_rst_line,
   input wire logic o_rst_line_oe_n,
   input wire logic o_case_open_line,
   input wire logic o_case_open_line_oe_n,
   input wire logic i_int_pending,
   input wire logic o_int_n,
   // converter and loop
   input wire logic o_conv_req,
   input wire logic [3:0] o_conv_chan,
   input wire logic i_conv_done,
   input wire logic o_loop_active
);
   // consecutive cycles the line has been driven, restarted by reset
   int low_cnt;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || o_rst_line_oe_n) begin
         low_cnt <= 0;
      end else begin
         low_cnt <= low_cnt + 1;
      end
   end
   // two clock domains here, so every property names its own clock and reset
   property p_pulse_len;
      @(posedge i_clk) disable iff (!i_rst_n)
         $rose(o_rst_line_oe_n) |-> low_cnt >= PULSE_CYCLES - 1;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pulse short");
   property p_drive_low;
      @(posedge i_clk) disable iff (!i_rst_n) !o_rst_line_oe_n |-> !o_rst_line;
   endproperty
   a_drive_low: assert property (p_drive_low) else $error("reset line driven high");
   property p_ext_req;
      @(posedge i_clk) disable iff (!i_rst_n)
         $fell(i_rst_line) && o_rst_line_oe_n |-> ##[1:10] !o_rst_line_oe_n;
   endproperty
   a_ext_req: assert property (p_ext_req) else $error("external pull not taken");
   property p_int;
      @(posedge i_clk) disable iff (!i_rst_n) !o_int_n |-> i_int_pending;
   endproperty
   a_int: assert property (p_int) else $error("interrupt without cause");
   property p_case;
      @(posedge i_clk) disable iff (!i_rst_n) !o_case_open_line_oe_n |-> !o_case_open_line;
   endproperty
   a_case: assert property (p_case) else $error("case line driven high");
   property p_first_chan;
      @(posedge i_clk) disable iff (!i_rst_n) $rose(o_conv_req) |-> o_conv_chan == 4'h0;
   endproperty
   a_first_chan: assert property (p_first_chan) else $error("pass not from channel 0");
   property p_chan_step;
      @(posedge i_clk) disable iff (!i_rst_n)
         o_conv_req && i_conv_done && o_conv_chan < CHANNELS - 1
         |=> !o_loop_active || o_conv_chan == $past(o_conv_chan) + 4'h1;
   endproperty
   a_chan_step: assert property (p_chan_step) else $error("channel order broken");
   property p_busy;
      @(posedge i_link_clk) disable iff (!i_link_rst_n)
         (i_link_wr || i_link_rd) && !o_link_busy |=> o_link_busy [*2];
   endproperty
   a_busy: assert property (p_busy) else $error("request not taken");
   c_loop: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_loop_active));
   c_pulse: cover property (@(posedge i_clk) disable iff (!i_rst_n) $fell(o_rst_line_oe_n));
   c_chan: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      o_conv_chan == 4'(CHANNELS - 1) && i_conv_done);
   c_ext: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      $fell(i_rst_line) && o_rst_line_oe_n);
endmodule

// File: verif/tb_mrlc_top.sv
// testbench for mrlc_top: host model, converter stub, pulled-up reset line
// assumes short pulse and loop period parameters
`timescale 1ns/100ps
module tb_mrlc_top;
   import mrlc_pkg::*;
   localparam int PULSE = 400;
   localparam int PERIOD = 200;
   typedef struct {int deg; logic [7:0] code;} mrlc_row_type;
   mrlc_row_type rows [4] = '{'{125, 8'h7d}, '{0, 8'h00}, '{-40, 8'hd8}, '{-1, 8'hff}};
   logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, lrst_n = 1'b0, ext_low = 1'b0;
   logic pend = 1'b0, done = 1'b0, wr, rd, busy, rvalid, line, drv, oe_n;
   logic case_l, case_oe_n, int_n, req, active;
   logic [7:0] addr, wdata, rdata, cdata, rdv, temp_code = 8'h00;
   logic [3:0] chan;
   int ccnt = 0, fails = 0, n_checks = 0;
   always #2 clk = ~clk;
   // first link edge comes early so the link reset lands inside the core reset
   initial begin
      #5.3;
      forever begin
         lclk = ~lclk;
         #16;
      end
   end
   assign line = (oe_n ? 1'b1 : drv) & !ext_low;
   assign cdata = (chan == 4'h0) ? temp_code : VOLT_CODE_NOMINAL;
   always @(negedge clk) begin
      done <= req && ccnt == 2;
      ccnt <= (req && ccnt < 2) ? ccnt + 1 : 0;
   end
   mrlc_host_model host (.i_link_clk(lclk), .o_link_wr(wr), .o_link_rd(rd),
      .o_link_addr(addr), .o_link_wdata(wdata), .i_link_busy(busy),
      .i_link_rvalid(rvalid), .i_link_rdata(rdata));
   mrlc_top #(.PULSE_CYCLES(PULSE), .PERIOD_CYCLES(PERIOD), .CHANNELS(10)) dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_link_clk(lclk), .i_link_rst_n(lrst_n),
      .i_link_wr(wr), .i_link_rd(rd), .i_link_addr(addr), .i_link_wdata(wdata),
      .o_link_busy(busy), .o_link_rvalid(rvalid), .o_link_rdata(rdata),
      .i_rst_line(line), .o_rst_line(drv), .o_rst_line_oe_n(oe_n),
      .o_case_open_line(case_l), .o_case_open_line_oe_n(case_oe_n),
      .i_int_pending(pend), .o_int_n(int_n), .o_conv_req(req), .o_conv_chan(chan),
      .i_conv_done(done), .i_conv_data(cdata), .o_loop_active(active));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic late;
      host.xfer(w, a, d, rdv, late);
      if (late) begin
         fails++;
         tally_and_finish();
      end
   endtask
   task automatic wait_oe(input logic lvl, input int lim);
      for (int n = 0; n < lim && oe_n !== lvl; n++) @(negedge clk);
      chk("reset line oe_n", {7'h0, lvl}, {7'h0, oe_n});
      if (oe_n !== lvl) tally_and_finish();
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge lclk);
      lrst_n = 1'b1;
      chk("power-on oe_n", 8'h00, {7'h0, oe_n});
      chk("power-on loop", 8'h00, {7'h0, active});
      wait_oe(1'b1, PULSE + 10);
      $display("test power-on done");
      reg_op(1'b1, ADDR_DEVICE_CONTROL, 8'h03);
      chk("loop started", 8'h01, {7'h0, active});
      foreach (rows[i]) begin
         temp_code = 8'(rows[i].deg);
         repeat (2 * PERIOD) @(negedge clk);
         reg_op(1'b0, ADDR_TEMPERATURE_RESULT, 8'h00);
         chk("temperature", rows[i].code, rdv);
         reg_op(1'b0, 8'h20, 8'h00);
         chk("supply", 8'hc0, rdv);
         $display("row %0d done", i);
      end
      @(negedge clk);
      pend = 1'b1;
      reg_op(1'b1, ADDR_DEVICE_CONTROL, 8'h43);
      chk("int enabled", 8'h00, {7'h0, int_n});
      chk("case driven", 8'h00, {7'h0, case_oe_n});
      reg_op(1'b1, ADDR_DEVICE_CONTROL, 8'h0b);
      chk("int cleared", 8'h01, {7'h0, int_n});
      repeat (PERIOD) @(negedge clk);
      chk("loop halted", 8'h00, {7'h0, active});
      $display("test control bits done");
      reg_op(1'b1, ADDR_DEVICE_CONTROL, 8'h10);
      reg_op(1'b0, ADDR_DEVICE_CONTROL, 8'h00);
      chk("sw reset pending", 8'h10, rdv);
      chk("sw reset blocked", 8'h01, {7'h0, oe_n});
      reg_op(1'b1, ADDR_INT_MASK2, 8'h80);
      wait_oe(1'b0, 20);
      reg_op(1'b0, ADDR_DEVICE_CONTROL, 8'h00);
      chk("sw bit cleared", 8'h00, rdv);
      reg_op(1'b0, ADDR_INT_MASK2, 8'h00);
      chk("mask2 kept", 8'h80, rdv);
      wait_oe(1'b1, PULSE + 10);
      $display("test software reset done");
      reg_op(1'b1, ADDR_DEVICE_CONTROL, 8'h83);
      chk("init no pulse", 8'h01, {7'h0, oe_n});
      reg_op(1'b0, ADDR_INT_MASK2, 8'h00);
      chk("init mask2", INT_MASK2_RESET, rdv);
      reg_op(1'b0, ADDR_DEVICE_CONTROL, 8'h00);
      chk("init control", 8'h08, rdv);
      $display("test init done");
      reg_op(1'b1, ADDR_DEVICE_CONTROL, 8'h03);
      repeat (PERIOD) @(negedge clk);
      ext_low = 1'b1;
      wait_oe(1'b0, 20);
      repeat (10) @(negedge clk);
      ext_low = 1'b0;
      reg_op(1'b0, ADDR_DEVICE_CONTROL, 8'h00);
      chk("ext reset control", 8'h08, rdv);
      chk("ext reset loop", 8'h00, {7'h0, active});
      reg_op(1'b0, ADDR_TEMPERATURE_RESULT, 8'h00);
      chk("ext reset keeps result", 8'hff, rdv);
      wait_oe(1'b1, PULSE + 10);
      repeat (20) @(negedge clk);
      chk("no pulse after release", 8'h01, {7'h0, oe_n});
      $display("test external reset done");
      reg_op(1'b1, 8'h20, 8'h55);
      reg_op(1'b0, 8'h20, 8'h00);
      chk("result write ignored", 8'hc0, rdv);
      reg_op(1'b0, 8'h50, 8'h00);
      chk("unmapped read", 8'h00, rdv);
      reg_op(1'b1, ADDR_DEVICE_CONTROL, 8'h01);
      // both sides reset together, so no toggle is left half crossed
      @(negedge clk);
      lrst_n = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge lclk);
      @(negedge clk);
      rst_n = 1'b1;
      lrst_n = 1'b1;
      chk("second reset oe_n", 8'h00, {7'h0, oe_n});
      chk("second reset loop", 8'h00, {7'h0, active});
      chk("second reset busy", 8'h00, {7'h0, busy});
      reg_op(1'b0, ADDR_DEVICE_CONTROL, 8'h00);
      chk("second reset control", DEVICE_CONTROL_RESET, rdv);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
bind mrlc_top mrlc_props #(.PULSE_CYCLES(PULSE_CYCLES), .CHANNELS(CHANNELS)) u_props (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_clk(i_link_clk), .i_link_rst_n(i_link_rst_n),
   .i_link_wr(i_link_wr), .i_link_rd(i_link_rd), .o_link_busy(o_link_busy),
   .i_rst_line(i_rst_line), .o_rst_line(o_rst_line), .o_rst_line_oe_n(o_rst_line_oe_n),
   .o_case_open_line(o_case_open_line), .o_case_open_line_oe_n(o_case_open_line_oe_n),
   .i_int_pending(i_int_pending), .o_int_n(o_int_n), .o_conv_req(o_conv_req),
   .o_conv_chan(o_conv_chan), .i_conv_done(i_conv_done), .o_loop_active(o_loop_active));
